// [cdsr_top.sv]
// top of the class-d stage routing and protection logic
// assumes synchronous inputs; analog monitors arrive as logic flags
// Overview of operation
// - stages float until all supplies valid
// - take straps after settle, then route pwm
// - modes 00 and 11: one input per fet
// - mode 01 uses four inputs, steered complementary
// - eight single-ended inputs drive stages internally
// - full bridge modes feed both fets
// - power-down low mutes all stage drive
// - power-down clears latched overcurrent shutdown
// - overcurrent stage pulls its fault output low
// - low threshold: fault follows event, no shutdown
// - high threshold latches until clear or idle
// - warning threshold asserts warning output only
// - shutdown temp: all faults, warning, auto resume
// - undervoltage: shut down, all faults asserted
// - high-side input map per mode
// - low-side input map per mode
module cdsr_top (
  input  wire logic        CLOCK,              // 40 MHz
  input  wire logic        SYS_RST,            // async, active high
  input  wire logic [7:0]  PWM_IN,             // pwm inputs 1..8
  input  wire logic        OUTPUT_CONFIG_STRAP0, // mode strap bit 0
  input  wire logic        OUTPUT_CONFIG_STRAP1, // mode strap bit 1
  input  wire logic        POWER_DOWN_MUTE_N,  // low mutes and resets
  input  wire logic        LOGIC_SUPPLY_OK,    // logic supply valid
  input  wire logic        GATE_DRIVE_SUPPLY_OK, // gate supply valid
  input  wire logic        HIGH_VOLTAGE_SUPPLY_OK, // hv supply valid
  input  wire logic [3:0]  OC_LOW,             // low threshold per stage
  input  wire logic [3:0]  OC_HIGH,            // high threshold per stage
  input  wire logic        TEMP_WARN,          // warning temperature
  input  wire logic        TEMP_SHUTDOWN,      // shutdown temperature
  output logic      [3:0]  STAGE_HS_ON,        // high-side fet gates
  output logic      [3:0]  STAGE_LS_ON,        // low-side fet gates
  output logic      [3:0]  STAGE_ENABLE,       // 0: stage floats
  output logic      [3:0]  CHANNEL_FAULT_N_O,  // open-drain level, low
  output logic      [3:0]  CHANNEL_FAULT_N_OE, // high while pulling low
  output logic             OVERTEMP_WARNING_N_O,  // always low when driven
  output logic             OVERTEMP_WARNING_N_OE  // high while pulling low
);
  cdsr_pkg::cdsr_state_t          state_reg;  // power sequencer state
  cdsr_pkg::cdsr_state_t          state_next; // next sequencer state
  logic [cdsr_pkg::SETTLE_W-1:0]  settle_reg; // settle counter
  logic [1:0]                     mode_reg;   // latched strap mode
  logic                           supply_ok;  // all monitors valid
  logic                           muted;      // power-down asserted
  logic [3:0]                     oc_latched; // per-stage shutdown
  logic [3:0]                     hs_sel;     // routed high-side pwm
  logic [3:0]                     ls_sel;     // routed low-side pwm
  logic [3:0]                     stage_ok;   // stage may drive

  assign supply_ok = LOGIC_SUPPLY_OK && GATE_DRIVE_SUPPLY_OK &&
                     HIGH_VOLTAGE_SUPPLY_OK;
  assign muted     = !POWER_DOWN_MUTE_N;

  // pick input n (1-based) of the eight pwm pins
  function automatic logic pwm_pick(input logic [7:0] pwm,
                                    input int         n);
    pwm_pick = pwm[n-1];
  endfunction

  // sequencer next state; supplies dropping returns to off
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cdsr_pkg::ST_OFF: begin
        if (supply_ok) begin
          state_next = cdsr_pkg::ST_SETTLE;
        end
      end
      cdsr_pkg::ST_SETTLE: begin
        if (!supply_ok) begin
          state_next = cdsr_pkg::ST_OFF;
        end else if (settle_reg ==
                     cdsr_pkg::SETTLE_W'(cdsr_pkg::SETTLE_CYCLES - 1)) begin
          state_next = cdsr_pkg::ST_RUN;
        end
      end
      cdsr_pkg::ST_RUN: begin
        if (!supply_ok) begin
          state_next = cdsr_pkg::ST_OFF;
        end
      end
      default: state_next = cdsr_pkg::ST_OFF;
    endcase
  end

  // sequencer state register
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= cdsr_pkg::ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // settle counter runs only while settling
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      settle_reg <= '0;
    end else if (state_reg == cdsr_pkg::ST_SETTLE) begin
      settle_reg <= settle_reg + 1'b1;
    end else begin
      settle_reg <= '0;
    end
  end

  // straps caught once on entry to run; later changes ignored
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mode_reg <= cdsr_pkg::MODE_HB4;
    end else if (state_reg == cdsr_pkg::ST_SETTLE &&
                 state_next == cdsr_pkg::ST_RUN) begin
      mode_reg <= {OUTPUT_CONFIG_STRAP1, OUTPUT_CONFIG_STRAP0};
    end
  end

  // routing matrix; each stage picks its fet inputs by mode
  always_comb begin
    hs_sel = '0;
    ls_sel = '0;
    case (mode_reg)
      cdsr_pkg::MODE_FB2Q: begin
        // four inputs, each steered to both fets of a bridge
        hs_sel = {pwm_pick(PWM_IN, 4), pwm_pick(PWM_IN, 3),
                  pwm_pick(PWM_IN, 2), pwm_pick(PWM_IN, 1)};
        ls_sel = {pwm_pick(PWM_IN, 3), pwm_pick(PWM_IN, 4),
                  pwm_pick(PWM_IN, 1), pwm_pick(PWM_IN, 2)};
      end
      cdsr_pkg::MODE_HB_FB: begin
        hs_sel = {pwm_pick(PWM_IN, 6), pwm_pick(PWM_IN, 5),
                  pwm_pick(PWM_IN, 3), pwm_pick(PWM_IN, 1)};
        ls_sel = {pwm_pick(PWM_IN, 5), pwm_pick(PWM_IN, 6),
                  pwm_pick(PWM_IN, 4), pwm_pick(PWM_IN, 2)};
      end
      cdsr_pkg::MODE_FB3L, cdsr_pkg::MODE_HB4: begin
        // dedicated input per fet; half-bridge mode shares this map
        hs_sel = {pwm_pick(PWM_IN, 7), pwm_pick(PWM_IN, 5),
                  pwm_pick(PWM_IN, 3), pwm_pick(PWM_IN, 1)};
        ls_sel = {pwm_pick(PWM_IN, 8), pwm_pick(PWM_IN, 6),
                  pwm_pick(PWM_IN, 4), pwm_pick(PWM_IN, 2)};
      end
      default: begin
        hs_sel = '0;
        ls_sel = '0;
      end
    endcase
  end

  // per-stage latch and shutdown gating
  genvar g;
  generate
    for (g = 0; g < cdsr_pkg::NUM_STAGE; g++) begin : g_stage
      cdsr_oc_latch u_latch (
        .clk       (CLOCK),
        .rst       (SYS_RST),
        .pdn_clear (muted),
        .oc_high   (OC_HIGH[g]),
        .pwm_any   (hs_sel[g] | ls_sel[g]),
        .latched   (oc_latched[g])
      );
      // any single cause turns the stage off
      assign stage_ok[g] = (state_reg == cdsr_pkg::ST_RUN) && supply_ok &&
                           !muted && !TEMP_SHUTDOWN &&
                           !oc_latched[g] && !OC_HIGH[g];
    end
  endgenerate

  // stage drivers, registered; fets never both on
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      STAGE_ENABLE <= '0;
      STAGE_HS_ON  <= '0;
      STAGE_LS_ON  <= '0;
    end else begin
      STAGE_ENABLE <= stage_ok;
      STAGE_HS_ON  <= stage_ok & hs_sel & ~ls_sel;
      STAGE_LS_ON  <= stage_ok & ls_sel & ~hs_sel;
    end
  end

  // fault pins: per-stage oc, or all on thermal or supply loss
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      CHANNEL_FAULT_N_OE <= '0;
      CHANNEL_FAULT_N_O  <= '0;
    end else begin
      CHANNEL_FAULT_N_O  <= '0;
      CHANNEL_FAULT_N_OE <= OC_LOW | OC_HIGH | oc_latched
                            | {4{TEMP_SHUTDOWN}}
                            | {4{!supply_ok}};
    end
  end

  // warning pin: either temperature threshold pulls it low
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      OVERTEMP_WARNING_N_O  <= 1'b0;
      OVERTEMP_WARNING_N_OE <= 1'b0;
    end else begin
      OVERTEMP_WARNING_N_O  <= 1'b0;
      OVERTEMP_WARNING_N_OE <= TEMP_WARN | TEMP_SHUTDOWN;
    end
  end

  chk_float_no_supply: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !supply_ok |=> STAGE_ENABLE == '0)
    else $error("stage enabled without supply");
  chk_mute_off: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    muted |=> (STAGE_HS_ON | STAGE_LS_ON) == '0)
    else $error("stage driven while muted");
  chk_low_oc_no_stop: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    OC_LOW[0] && stage_ok[0] |=> CHANNEL_FAULT_N_OE[0] && STAGE_ENABLE[0])
    else $error("low threshold stopped stage");
  chk_fault_follow: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    OC_LOW[1] |=> CHANNEL_FAULT_N_OE[1])
    else $error("fault not asserted");
  chk_high_oc_off: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    OC_HIGH[0] |=> !STAGE_ENABLE[0] ##1 !STAGE_ENABLE[0])
    else $error("high threshold did not shut stage");
  chk_tsd_all: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    TEMP_SHUTDOWN |=> CHANNEL_FAULT_N_OE == 4'hf && STAGE_ENABLE == '0
      && OVERTEMP_WARNING_N_OE) else $error("thermal shutdown wrong");
  chk_warn_only: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    $rose(TEMP_WARN) |=> OVERTEMP_WARNING_N_OE)
    else $error("warning not asserted");
  chk_uv_faults: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !supply_ok |=> CHANNEL_FAULT_N_OE == 4'hf)
    else $error("undervoltage faults missing");
  chk_map_fb2q: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    mode_reg == cdsr_pkg::MODE_FB2Q && stage_ok[1] && PWM_IN[1]
      && !PWM_IN[0] |=> STAGE_HS_ON[1]) else $error("mode 01 map");
endmodule : cdsr_top // cdsr_top

// [cdsr_pkg.sv]
// shared constants for the class-d stage routing and protection block
// assumes a single 40 MHz clock domain and synchronous pin inputs
package cdsr_pkg;
  // strap mode encodings {strap1, strap0}
  localparam logic [1:0] MODE_FB3L  = 2'h0;  // dual full bridge, 3-level
  localparam logic [1:0] MODE_FB2Q  = 2'h1;  // dual full bridge, 2-quadrant
  localparam logic [1:0] MODE_HB_FB = 2'h2;  // two half plus one full
  localparam logic [1:0] MODE_HB4   = 2'h3;  // four half bridges
  localparam int         NUM_STAGE  = 4;     // output stages a..d
  localparam int         NUM_PWM    = 8;     // pwm inputs 1..8
  // idle time with no pwm edge that counts as clocking stopped
  localparam int         PWM_IDLE_NS     = 10000;
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         PWM_IDLE_CYCLES = (PWM_IDLE_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int         IDLE_W          = 10;  // holds 400
  // supply settle time before straps are taken
  localparam int         SETTLE_NS       = 1000;
  localparam int         SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1)
                                           / CLK_PERIOD_NS;
  localparam int         SETTLE_W        = 6;   // holds 40
  // power sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_OFF    = 3'h1,  // supplies not valid, outputs floating
    ST_SETTLE = 3'h2,  // supplies valid, waiting to settle
    ST_RUN    = 3'h4   // straps latched, routing active
  } cdsr_state_t;
endpackage : cdsr_pkg

// [cdsr_oc_latch.sv]
// per-stage high-threshold overcurrent latch with pwm idle detect
// assumes pwm pair of the stage is synchronous to the clock
module cdsr_oc_latch (
  input  wire logic clk,         // system clock
  input  wire logic rst,         // async reset, active high
  input  wire logic pdn_clear,   // power-down clears the latch
  input  wire logic oc_high,     // high threshold exceeded
  input  wire logic pwm_any,     // pwm activity of this stage
  output logic      latched      // stage is shut down
);
  logic                       pwm_d_reg;   // previous pwm level
  logic [cdsr_pkg::IDLE_W-1:0] idle_reg;   // cycles since last edge
  logic                       idle;        // clocking has stopped

  assign idle = (idle_reg ==
                 cdsr_pkg::IDLE_W'(cdsr_pkg::PWM_IDLE_CYCLES));

  // idle counter restarts on any pwm edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm_d_reg <= 1'b0;
      idle_reg  <= '0;
    end else begin
      pwm_d_reg <= pwm_any;
      if (pwm_any != pwm_d_reg) begin
        idle_reg <= '0;
      end else if (!idle) begin
        idle_reg <= idle_reg + 1'b1;
      end
    end
  end

  // set wins over every clear; clear needs fault gone and power-down or pwm idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latched <= 1'b0;
    end else if (oc_high) begin
      latched <= 1'b1;
    end else if (pdn_clear) begin
      latched <= 1'b0;
    end else if (idle) begin
      latched <= 1'b0;
    end
  end

  chk_latch_holds: assert property (@(posedge clk) disable iff (rst)
    oc_high |=> latched) else $error("oc latch did not set");
endmodule : cdsr_oc_latch // cdsr_oc_latch

// [cdsr_pwm_ctrl.sv]
// pwm controller model facing the stage routing block
// assumes the block's clock; fault pins have external pull-ups
module cdsr_pwm_ctrl (
  input  wire logic       clk,          // system clock
  input  wire logic       rst,          // async reset, active high
  input  wire logic       run,          // low: clocking stopped
  input  wire logic       chop,         // toggle pattern bits each cycle
  input  wire logic [7:0] pattern,      // pwm levels to present
  input  wire logic [3:0] fault_oe,     // block pulls fault low
  output logic      [7:0] pwm,          // pwm inputs 1..8
  output logic      [3:0] fault_wire,   // resolved fault pin levels
  output logic      [1:0] pair_fault_n  // wired-or pairs a|b, c|d
);
  timeunit 1ns;
  timeprecision 1ps;
  // stopping holds all lines low so the block sees no edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwm <= 8'h00;
    end else if (!run) begin
      pwm <= 8'h00;
    end else begin
      pwm <= chop ? (pwm ^ pattern) : pattern;
    end
  end
  // pull-up wins unless the block drives low
  assign fault_wire   = ~fault_oe;
  assign pair_fault_n = {&fault_wire[3:2], &fault_wire[1:0]};
endmodule  // cdsr_pwm_ctrl

// [cdsr_tb_top.sv]
// self-checking bench for the stage routing and protection top
// assumes cdsr_top and the pwm controller model are compiled first
module cdsr_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock   = 1'b0;
  logic       sys_rst = 1'b1;
  logic       strap0  = 1'b0;  // fixed while running
  logic       strap1  = 1'b0;
  logic       mute_n  = 1'b1;
  logic [2:0] sup_ok  = 3'h0;  // {hv, gate, logic}
  logic [3:0] oc_low  = 4'h0;
  logic [3:0] oc_high = 4'h0;
  logic       t_warn  = 1'b0;
  logic       t_shut  = 1'b0;
  logic       run     = 1'b1;
  logic       chop    = 1'b0;
  logic [7:0] pattern = 8'h00;
  logic [7:0] pwm;
  logic [3:0] hs, ls, en, f_oe, f_wire;
  logic       w_oe;
  logic [3:0] f_o;   // fault pin drive level, must be low
  logic       w_o;   // warning pin drive level, must be low
  logic [1:0] pair_n;
  int         errors      = 0;
  int         checks_done = 0;
  always #12.5 clock = ~clock;
  cdsr_pwm_ctrl ctrl (.clk(clock), .rst(sys_rst), .run(run), .chop(chop),
    .pattern(pattern), .fault_oe(f_oe), .pwm(pwm), .fault_wire(f_wire),
    .pair_fault_n(pair_n));
  cdsr_top dut (.CLOCK(clock), .SYS_RST(sys_rst), .PWM_IN(pwm),
    .OUTPUT_CONFIG_STRAP0(strap0), .OUTPUT_CONFIG_STRAP1(strap1),
    .POWER_DOWN_MUTE_N(mute_n), .LOGIC_SUPPLY_OK(sup_ok[0]),
    .GATE_DRIVE_SUPPLY_OK(sup_ok[1]), .HIGH_VOLTAGE_SUPPLY_OK(sup_ok[2]),
    .OC_LOW(oc_low), .OC_HIGH(oc_high), .TEMP_WARN(t_warn),
    .TEMP_SHUTDOWN(t_shut), .STAGE_HS_ON(hs), .STAGE_LS_ON(ls),
    .STAGE_ENABLE(en), .CHANNEL_FAULT_N_O(f_o), .CHANNEL_FAULT_N_OE(f_oe),
    .OVERTEMP_WARNING_N_O(w_o), .OVERTEMP_WARNING_N_OE(w_oe));
  // one compare, counted
  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // settle just past a rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // bounded wait for the stage enables to reach a value
  task automatic wait_en(input logic [3:0] exp);
    int i;
    i = 0;
    while (en !== exp && i < 60) begin
      cyc(1);
      i++;
    end
    check("stage_enable", {4'h0, en}, {4'h0, exp});
  endtask
  // expected {ls, hs}; both selected high means both held off
  function automatic logic [7:0] exp_gates(input logic [1:0] m,
                                           input logic [7:0] p);
    int hi[4][4] = '{'{0,2,4,6}, '{0,1,2,3}, '{0,2,4,5}, '{0,2,4,6}};
    int lo[4][4] = '{'{1,3,5,7}, '{1,0,3,2}, '{1,3,5,4}, '{1,3,5,7}};
    logic [7:0] g;
    for (int s = 0; s < 4; s++) begin
      g[s]     = p[hi[m][s]] & ~p[lo[m][s]];
      g[s + 4] = p[lo[m][s]] & ~p[hi[m][s]];
    end
    return g;
  endfunction
  // stages stay off until supplies have settled
  task automatic t_power_up;
    check("enable_off", {4'h0, en}, 8'h00);
    @(posedge clock);
    sup_ok <= 3'h7;
    cyc(20);
    check("enable_settle", {4'h0, en}, 8'h00);
    wait_en(4'hf);
  endtask
  // every mode re-read after a drop of one supply, one-hot per input
  task automatic t_modes;
    logic [1:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k + 1);
      @(posedge clock);
      strap0 <= m[0];
      strap1 <= m[1];
      sup_ok <= 3'(~(3'h1 << (k % 3)));
      cyc(3);
      check("uv_faults", {4'h0, f_oe}, 8'h0f);
      check("uv_enable", {4'h0, en}, 8'h00);
      @(posedge clock);
      sup_ok <= 3'h7;
      wait_en(4'hf);
      for (int b = 0; b < 8; b++) begin
        @(posedge clock);
        pattern <= 8'h01 << b;
        cyc(3);
        check("gates", {ls, hs}, exp_gates(m, 8'h01 << b));
      end
      check("gates_last", {ls, hs}, exp_gates(m, 8'h80));
    end
    @(posedge clock);
    pattern <= 8'h01;
    cyc(3);
    check("gates_fb", {ls, hs}, 8'h01);
  endtask
  // mute removes drive, release restores it
  task automatic t_mute;
    @(posedge clock);
    mute_n <= 1'b0;
    cyc(3);
    check("mute_gates", {ls, hs}, 8'h00);
    check("mute_enable", {4'h0, en}, 8'h00);
    @(posedge clock);
    mute_n <= 1'b1;
    wait_en(4'hf);
  endtask
  // low threshold flags without shutdown
  task automatic t_oc_low;
    @(posedge clock);
    oc_low <= 4'h3;
    cyc(3);
    check("low_fault", {4'h0, f_oe}, 8'h03);
    check("low_enable", {4'h0, en}, 8'h0f);
    @(posedge clock);
    oc_low <= 4'h0;
    cyc(3);
    check("low_clear", {4'h0, f_oe}, 8'h00);
  endtask
  // one-cycle high threshold pulse on stage a
  task automatic trip_a;
    @(posedge clock);
    oc_high <= 4'h1;
    @(posedge clock);
    oc_high <= 4'h0;
    cyc(3);
    check("trip_enable", {4'h0, en}, 8'h0e);
    check("trip_fault", {4'h0, f_oe}, 8'h01);
  endtask
  // latch holds while clocking, clears on idle or on mute
  task automatic t_oc_high;
    @(posedge clock);
    chop <= 1'b1;
    trip_a;
    check("pair_fault", {6'h00, pair_n}, 8'h02);
    cyc(50);
    check("latch_hold", {4'h0, f_oe}, 8'h01);
    @(posedge clock);
    run <= 1'b0;
    cyc(420);
    check("idle_clear", {4'h0, f_oe}, 8'h00);
    wait_en(4'hf);
    @(posedge clock);
    run <= 1'b1;
    trip_a;
    @(posedge clock);
    mute_n <= 1'b0;
    cyc(3);
    @(posedge clock);
    mute_n <= 1'b1;
    wait_en(4'hf);
    check("mute_clear", {4'h0, f_oe}, 8'h00);
  endtask
  // warning alone, then shutdown and automatic resume
  task automatic t_temp;
    @(posedge clock);
    t_warn <= 1'b1;
    cyc(3);
    check("warn", {7'h00, w_oe}, 8'h01);
    check("warn_enable", {4'h0, en}, 8'h0f);
    @(posedge clock);
    t_shut <= 1'b1;
    cyc(3);
    check("hot_faults", {4'h0, f_oe}, 8'h0f);
    check("hot_enable", {4'h0, en}, 8'h00);
    check("hot_warn", {7'h00, w_oe}, 8'h01);
    check("pin_levels", {3'h0, w_o, f_o}, 8'h00);
    @(posedge clock);
    t_shut <= 1'b0;
    t_warn <= 1'b0;
    wait_en(4'hf);
    check("cool", {3'h0, w_oe, f_oe}, 8'h00);
  endtask
  // verdict and end of run
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    cyc(1);
    t_power_up;
    t_modes;
    t_mute;
    t_oc_low;
    t_oc_high;
    t_temp;
    final_report;
  end
  // watchdog, well past the roughly 900 cycles the run needs
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    $display("watchdog expired");
    final_report;
  end
endmodule  // cdsr_tb_top
